/* File: rtl/spl_pkg.sv */
// Constants and types for the sector protection logic
package spl_pkg;
  // Clock and unlock rate-limit timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int UNLOCK_GAP_US = 100;
  localparam int UNLOCK_GAP_CYC = UNLOCK_GAP_US * 1000 / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PWD_LO = 8'h08;
  localparam logic [7:0] OFS_PWD_HI = 8'h0c;
  localparam logic [7:0] OFS_SECT = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SECT_LSB = 8;
  localparam int CMD_VAL_BIT = 16;
  localparam int CMD_MODE_LSB = 17;
  // Status word fields
  localparam int ST_WIP_BIT = 0;
  localparam int ST_PERR_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_MODE_LSB = 3;
  localparam int ST_RDPROT_BIT = 5;
  // Protection mode selection encodings
  localparam logic [1:0] MODE_NONE = 2'h3;
  localparam logic [1:0] MODE_PERSIST = 2'h2;
  localparam logic [1:0] MODE_PASSWORD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL = 2'h0;
  // Reset values
  localparam logic [63:0] PWD_RESET = 64'hffffffffffffffff;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;
  // Commands
  typedef enum logic [3:0] {
    CMD_NOP = 4'b0000,
    CMD_PPB_PGM = 4'b0001,
    CMD_PPB_ERS = 4'b0010,
    CMD_DYB_WR = 4'b0011,
    CMD_LOCK_CLR = 4'b0100,
    CMD_PWD_PGM = 4'b0101,
    CMD_PWD_UNLOCK = 4'b0110,
    CMD_MODE_PGM = 4'b0111,
    CMD_SOFT_RST = 4'b1000,
    CMD_CLR_STAT = 4'b1001
  } spl_cmd_t;
  // Engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_FAIL = 2'b10
  } spl_state_t;
endpackage : spl_pkg

/* File: rtl/spl_sector_protection_logic.sv */
// Sector protection logic with APB register access
`timescale 1ns/1ps
// Overview of operation
// - Sectors whose persistent bit is 0 are shown protected.
// - Persistent bits program to 0 singly, erase to 1 all together.
// - Persistent program or erase fails unchanged while lock is 0.
// - Busy flag in status shows persistent program or erase progress.
// - Volatile write sets a sector bit to 0 or 1.
// - Volatile bits are rewritable without limit, one sector at a time.
// - Lock 0 freezes all persistent bits, lock 1 lets them change.
// - Lock clear command drops the lock to 0.
// - Persistent mode: reset sets lock 1, no command sets it again.
// - Software reset leaves the lock alone.
// - Password mode: reset clears lock, only good unlock sets it.
// - Sector unprotected only when persistent and volatile bits are 1.
// - Reset by presetn, or software reset when not busy, returns volatile bits to unprotected.
// - In password mode password reads and programs are ignored.
// - Password programming only moves cells from 1 to 0.
// - Password storage starts all ones, own access path only.
// - Any 64-bit value is an acceptable password.
// - Wrong password: lock kept, error set, busy stays set.
// - After a failed unlock, the next attempt waits at least 100 us.
// - Correct password clears busy at once without the delay.
// - Mode selection bits can never be erased.
// - Read protection forces reads to the boot sector address.
// - Mode bits 11 none, 10 persistent, 01 password, 00 fails.
module spl_sector_protection_logic #(
  parameter int NUM_SECTORS = 256,
  parameter int SECT_W = 8,
  parameter int PGM_CYCLES = 64,
  parameter int ERS_CYCLES = 256,
  parameter int UNLOCK_CYCLES = spl_pkg::UNLOCK_GAP_CYC,
  parameter logic [31:0] BOOT_ADDR = 32'h00000000,
  parameter logic [SECT_W-1:0] BOOT_SECT = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_SECTORS-1:0] sector_protect
);

  // Register decode used by the error path only
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == spl_pkg::OFS_CMD) || (a == spl_pkg::OFS_STAT) ||
      (a == spl_pkg::OFS_PWD_LO) || (a == spl_pkg::OFS_PWD_HI) ||
      (a == spl_pkg::OFS_SECT) || (a == spl_pkg::OFS_ADDR) ||
      (a == spl_pkg::OFS_CTRL);
  endfunction : reg_hit

  logic [NUM_SECTORS-1:0] pers;
  logic [NUM_SECTORS-1:0] vol;
  logic [63:0] pwd;
  logic [63:0] pwd_in;
  logic [1:0] mode;
  logic lock;
  logic ld;
  logic perr;
  logic rd_prot;
  logic [SECT_W-1:0] sect_q;
  logic [31:0] addr_q;
  logic [SECT_W-1:0] op_sect;
  logic [1:0] op_mode;
  logic [15:0] timer;
  logic [15:0] rate_t;
  spl_pkg::spl_state_t state;
  spl_pkg::spl_cmd_t op;
  logic [31:0] next_rdata;

  // Bus phases and command fields
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire cmd_go = wr_en && (paddr == spl_pkg::OFS_CMD);
  wire [3:0] c_op = pwdata[spl_pkg::CMD_OP_LSB +: 4];
  wire [SECT_W-1:0] c_sect = pwdata[spl_pkg::CMD_SECT_LSB +: SECT_W];
  wire c_val = pwdata[spl_pkg::CMD_VAL_BIT];
  wire [1:0] c_mode = pwdata[spl_pkg::CMD_MODE_LSB +: 2];
  wire idle_go = cmd_go && (state == spl_pkg::ST_IDLE);
  wire pw_mode = (mode == spl_pkg::MODE_PASSWORD);
  wire done = (state == spl_pkg::ST_BUSY) && (timer == 16'h0000);
  wire work_pending_flag = (state != spl_pkg::ST_IDLE);
  wire pwd_match = (pwd_in == pwd);
  wire sect_ok = (32'(c_sect) < NUM_SECTORS);
  wire q_ok = (32'(sect_q) < NUM_SECTORS);
  wire [SECT_W-1:0] q_idx = q_ok ? sect_q : '0;

  // APB handshake: zero wait states, error on unmapped offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~reg_hit(paddr);
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = spl_pkg::DATA_ZERO;
    case (paddr)
      spl_pkg::OFS_STAT: begin
        next_rdata[spl_pkg::ST_WIP_BIT] = work_pending_flag;
        next_rdata[spl_pkg::ST_PERR_BIT] = perr;
        next_rdata[spl_pkg::ST_LOCK_BIT] = lock;
        next_rdata[spl_pkg::ST_MODE_LSB +: 2] = mode;
        next_rdata[spl_pkg::ST_RDPROT_BIT] = rd_prot;
      end
      spl_pkg::OFS_PWD_LO: next_rdata = pw_mode ? '0 : pwd[31:0];
      spl_pkg::OFS_PWD_HI: next_rdata = pw_mode ? '0 : pwd[63:32];
      spl_pkg::OFS_SECT: begin
        next_rdata[0] = q_ok & pers[q_idx];
        next_rdata[1] = q_ok & vol[q_idx];
        next_rdata[2] = q_ok & sector_protect[q_idx];
        // Readable flag, clear for a non-boot sector under read protection
        next_rdata[3] = ~rd_prot | (sect_q == BOOT_SECT);
      end
      spl_pkg::OFS_ADDR: next_rdata = rd_prot ? BOOT_ADDR : addr_q;
      spl_pkg::OFS_CTRL: next_rdata[0] = rd_prot;
      default: next_rdata = spl_pkg::DATA_ZERO;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= spl_pkg::DATA_ZERO;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Plain data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwd_in <= '0;
      sect_q <= '0;
      addr_q <= spl_pkg::DATA_ZERO;
      rd_prot <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        spl_pkg::OFS_PWD_LO: pwd_in[31:0] <= pwdata;
        spl_pkg::OFS_PWD_HI: pwd_in[63:32] <= pwdata;
        spl_pkg::OFS_SECT: sect_q <= pwdata[SECT_W-1:0];
        spl_pkg::OFS_ADDR: addr_q <= pwdata;
        spl_pkg::OFS_CTRL: rd_prot <= pwdata[0];
        default: rd_prot <= rd_prot;
      endcase
    end
  end

  // Operation engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spl_pkg::ST_IDLE;
      op <= spl_pkg::CMD_NOP;
      op_sect <= '0;
      op_mode <= spl_pkg::MODE_NONE;
      timer <= 16'h0000;
      perr <= 1'b0;
    end else begin
      case (state)
        spl_pkg::ST_IDLE: begin
          if (idle_go) begin
            op <= spl_pkg::spl_cmd_t'(c_op);
            op_sect <= c_sect;
            op_mode <= c_mode;
            case (spl_pkg::spl_cmd_t'(c_op))
              spl_pkg::CMD_PPB_PGM, spl_pkg::CMD_PPB_ERS: begin
                if (!lock) begin
                  state <= spl_pkg::ST_FAIL;
                  perr <= 1'b1;
                end else begin
                  state <= spl_pkg::ST_BUSY;
                  timer <= (c_op == spl_pkg::CMD_PPB_PGM) ?
                    16'(PGM_CYCLES - 1) : 16'(ERS_CYCLES - 1);
                end
              end
              spl_pkg::CMD_PWD_PGM: begin
                if (!pw_mode) begin
                  state <= spl_pkg::ST_BUSY;
                  timer <= 16'(PGM_CYCLES - 1);
                end
              end
              spl_pkg::CMD_PWD_UNLOCK: begin
                if (!pwd_match) begin
                  state <= spl_pkg::ST_FAIL;
                  perr <= 1'b1;
                end else begin
                  state <= spl_pkg::ST_BUSY;
                  timer <= 16'h0000;
                end
              end
              spl_pkg::CMD_MODE_PGM: begin
                if (mode != spl_pkg::MODE_NONE ||
                    (mode & c_mode) == spl_pkg::MODE_ILLEGAL) begin
                  state <= spl_pkg::ST_FAIL;
                  perr <= 1'b1;
                end else begin
                  state <= spl_pkg::ST_BUSY;
                  timer <= 16'(PGM_CYCLES - 1);
                end
              end
              spl_pkg::CMD_SOFT_RST, spl_pkg::CMD_CLR_STAT: perr <= 1'b0;
              default: perr <= perr;
            endcase
          end
        end
        spl_pkg::ST_BUSY: begin
          if (done) begin
            state <= spl_pkg::ST_IDLE;
          end else begin
            timer <= timer - 16'h0001;
          end
        end
        spl_pkg::ST_FAIL: begin
          // no exit until the unlock gap has passed
          if (cmd_go && rate_t == 16'h0000 &&
              (c_op == spl_pkg::CMD_CLR_STAT ||
               c_op == spl_pkg::CMD_SOFT_RST)) begin
            state <= spl_pkg::ST_IDLE;
            perr <= 1'b0;
          end
        end
        default: state <= spl_pkg::ST_IDLE;
      endcase
    end
  end

  // unlock rate timer, started by a failed unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_t <= 16'h0000;
    end else if (idle_go && c_op == spl_pkg::CMD_PWD_UNLOCK &&
                 !pwd_match) begin
      rate_t <= 16'(UNLOCK_CYCLES - 1);
    end else if (rate_t != 16'h0000) begin
      rate_t <= rate_t - 16'h0001;
    end
  end

  // lock bit, reset by presetn only, loaded from mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= 1'b0;
      ld <= 1'b1;
    end else if (ld) begin
      ld <= 1'b0;
      lock <= ~pw_mode;
    end else if (idle_go && c_op == spl_pkg::CMD_LOCK_CLR) begin
      lock <= 1'b0;
    end else if (idle_go && c_op == spl_pkg::CMD_PWD_UNLOCK &&
                 pwd_match && pw_mode) begin
      lock <= 1'b1;
    end
  end

  // volatile bits, set to 1 by presetn or by software reset when not busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vol <= '1;
    end else if (cmd_go && state != spl_pkg::ST_BUSY &&
                 c_op == spl_pkg::CMD_SOFT_RST) begin
      vol <= '1;
    end else if (idle_go && c_op == spl_pkg::CMD_DYB_WR && sect_ok) begin
      vol[c_sect] <= c_val;
    end
  end

  // Nonvolatile storage, cleared only at power-on
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pers <= '1;
      pwd <= spl_pkg::PWD_RESET;
      mode <= spl_pkg::MODE_NONE;
    end else if (done) begin
      case (op)
        spl_pkg::CMD_PPB_PGM: begin
          if (32'(op_sect) < NUM_SECTORS) begin
            pers[op_sect] <= 1'b0;
          end
        end
        spl_pkg::CMD_PPB_ERS: pers <= '1;
        spl_pkg::CMD_PWD_PGM: pwd <= pwd & pwd_in;
        spl_pkg::CMD_MODE_PGM: mode <= mode & op_mode;
        default: mode <= mode;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_protect <= '1;
    end else begin
      sector_protect <= ~(pers & vol);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ppb_try_s;
    idle_go && (c_op == spl_pkg::CMD_PPB_PGM ||
      c_op == spl_pkg::CMD_PPB_ERS);
  endsequence
  sequence unlock_s;
    idle_go && c_op == spl_pkg::CMD_PWD_UNLOCK;
  endsequence

  ppb_frozen_a: assert property (
    ppb_try_s and !lock |=> state == spl_pkg::ST_FAIL && perr
      ##1 pers == $past(pers, 2))
    else $error("persistent bits changed while locked");
  ppb_busy_a: assert property (
    ppb_try_s and lock |=> work_pending_flag [*2])
    else $error("busy flag missing during persistent work");
  ppb_pgm_a: assert property (
    done && op == spl_pkg::CMD_PPB_PGM |=> !pers[op_sect])
    else $error("persistent bit not programmed");
  ppb_erase_a: assert property (
    done && op == spl_pkg::CMD_PPB_ERS |=> &pers)
    else $error("persistent bits not erased");
  prot_map_a: assert property (
    !ld |=> sector_protect == ~($past(pers) & $past(vol)))
    else $error("sector protection mismatch");
  lock_load_a: assert property (
    $fell(ld) |-> lock == (mode != spl_pkg::MODE_PASSWORD))
    else $error("lock reset value wrong for mode");
  lock_stuck_a: assert property (
    !ld && !lock && !pw_mode |=> !lock)
    else $error("lock set again in persistent mode");
  soft_reset_a: assert property (
    cmd_go && !work_pending_flag && c_op == spl_pkg::CMD_SOFT_RST
      |=> &vol && lock == $past(lock))
    else $error("software reset handling wrong");
  pwd_hidden_a: assert property (
    idle_go && c_op == spl_pkg::CMD_PWD_PGM && pw_mode
      |=> state == spl_pkg::ST_IDLE)
    else $error("password program not ignored");
  unlock_bad_a: assert property (
    unlock_s and !pwd_match
      |=> state == spl_pkg::ST_FAIL && perr && lock == $past(lock))
    else $error("failed unlock handling wrong");
  unlock_ok_a: assert property (
    unlock_s and pwd_match and pw_mode |=> lock ##1 !work_pending_flag)
    else $error("good unlock not fast");
  rate_hold_a: assert property (
    state == spl_pkg::ST_FAIL && rate_t != 16'h0000
      |=> state == spl_pkg::ST_FAIL)
    else $error("unlock gap not enforced");
  mode_bad_a: assert property (
    idle_go && c_op == spl_pkg::CMD_MODE_PGM &&
      (mode & c_mode) == spl_pkg::MODE_ILLEGAL
      |=> perr && mode == $past(mode))
    else $error("illegal mode accepted");

endmodule : spl_sector_protection_logic

/* File: testbench/spl_host_model.sv */
// Host-side APB master model issuing protection commands
`timescale 1ns/1ps
module spl_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int timeouts = 0;
  logic last_err = 1'b0;
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      timeouts++;
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale write data is not left on the bus
    pwdata <= ~d;
  endtask : xfer
endmodule : spl_host_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the sector protection logic
`timescale 1ns/1ps
module tb_top;
  localparam int UNLK = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic por_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [255:0] sp;
  int failures = 0;
  int check_count = 0;
  spl_sector_protection_logic #(.PGM_CYCLES(4), .ERS_CYCLES(8),
      .UNLOCK_CYCLES(UNLK)) i_dut (.pclk(pclk), .presetn(presetn),
      .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sector_protect(sp));
  spl_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
  // 125 MHz clock
  initial begin
    forever #4 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic stop_test();
    failures += i_host.timeouts;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Command word: op, sector, volatile value, mode value
  function automatic logic [31:0] mk(logic [3:0] op, logic [7:0] s,
      logic v, logic [1:0] m);
    mk = {13'h0, m, v, s, 4'h0, op};
  endfunction : mk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h00000000, q);
    chk(nm, e, q);
  endtask : rd
  // Poll busy with a bound
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      i_host.xfer(1'b0, spl_pkg::OFS_STAT, 32'h00000000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    if (q[0] !== 1'b0) begin
      failures++;
      stop_test();
    end
  endtask : wait_idle
  task automatic prot(int k, logic e);
    repeat (2) @(posedge pclk);
    chk("sector_protect", {31'h0, e}, {31'h0, sp[k]});
  endtask : prot
  task automatic pwd(logic [31:0] lo, logic [31:0] hi);
    wr(spl_pkg::OFS_PWD_LO, lo);
    wr(spl_pkg::OFS_PWD_HI, hi);
  endtask : pwd
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge pclk);
    rd("status", spl_pkg::OFS_STAT, 32'h0000001c);
    prot(9, 1'b0);
    rd("unmapped", 8'h40, 32'h00000000);
    chk("slverr", 32'h1, {31'h0, i_host.last_err});
    $display("test reset done");
    // Volatile bits rewritten back to back
    wr(spl_pkg::OFS_CMD, mk(4'h3, 8'h03, 1'b0, 2'h0));
    prot(3, 1'b1);
    wr(spl_pkg::OFS_CMD, mk(4'h3, 8'h03, 1'b1, 2'h0));
    prot(3, 1'b0);
    // Persistent program, busy shown meanwhile
    wr(spl_pkg::OFS_CMD, mk(4'h1, 8'h05, 1'b0, 2'h0));
    rd("busy", spl_pkg::OFS_STAT, 32'h0000001d);
    wait_idle();
    prot(5, 1'b1);
    prot(6, 1'b0);
    $display("test sector bits done");
    // Locked erase fails without change
    wr(spl_pkg::OFS_CMD, mk(4'h4, 8'h00, 1'b0, 2'h0));
    wr(spl_pkg::OFS_CMD, mk(4'h2, 8'h00, 1'b0, 2'h0));
    rd("lock fail", spl_pkg::OFS_STAT, 32'h0000001b);
    wr(spl_pkg::OFS_CMD, mk(4'h9, 8'h00, 1'b0, 2'h0));
    prot(5, 1'b1);
    wr(spl_pkg::OFS_CMD, mk(4'h3, 8'h03, 1'b0, 2'h0));
    wr(spl_pkg::OFS_CMD, mk(4'h8, 8'h00, 1'b0, 2'h0));
    rd("soft reset", spl_pkg::OFS_STAT, 32'h00000018);
    prot(3, 1'b0);
    prot(5, 1'b1);
    // Read protection forces address and hides other sectors
    wr(spl_pkg::OFS_ADDR, 32'h00012340);
    rd("addr", spl_pkg::OFS_ADDR, 32'h00012340);
    wr(spl_pkg::OFS_CTRL, 32'h00000001);
    wr(spl_pkg::OFS_SECT, 32'h00000005);
    rd("addr forced", spl_pkg::OFS_ADDR, 32'h00000000);
    rd("sect state", spl_pkg::OFS_SECT, 32'h00000006);
    rd("rd prot", spl_pkg::OFS_STAT, 32'h00000038);
    wr(spl_pkg::OFS_CTRL, 32'h00000000);
    $display("test lock done");
    // Mode value 00 is refused, fail state holds busy
    wr(spl_pkg::OFS_CMD, mk(4'h7, 8'h00, 1'b0, 2'h0));
    $display("test illegal mode done");
    hw_and_pwd();
    stop_test();
  end
  // Password store, password mode and unlock
  task automatic hw_and_pwd();
    i_host.xfer(1'b0, spl_pkg::OFS_STAT, 32'h0, q);
    chk("mode fail", 32'h0000001b, q & 32'h0000001b);
    wr(spl_pkg::OFS_CMD, mk(4'h9, 8'h00, 1'b0, 2'h0));
    rd("pwd blank", spl_pkg::OFS_PWD_LO, 32'hffffffff);
    pwd(32'h1234ffff, 32'h89abcdef);
    wr(spl_pkg::OFS_CMD, mk(4'h5, 8'h00, 1'b0, 2'h0));
    wait_idle();
    pwd(32'hffff5678, 32'h89abcdef);
    wr(spl_pkg::OFS_CMD, mk(4'h5, 8'h00, 1'b0, 2'h0));
    wait_idle();
    rd("pwd lo", spl_pkg::OFS_PWD_LO, 32'h12345678);
    rd("pwd hi", spl_pkg::OFS_PWD_HI, 32'h89abcdef);
    wr(spl_pkg::OFS_CMD, mk(4'h7, 8'h00, 1'b0, 2'h1));
    wait_idle();
    rd("pwd hidden", spl_pkg::OFS_PWD_LO, 32'h00000000);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd("pwd mode", spl_pkg::OFS_STAT, 32'h00000008);
    pwd(32'h00000000, 32'h00000000);
    // Program ignored, so the stored password survives
    wr(spl_pkg::OFS_CMD, mk(4'h5, 8'h00, 1'b0, 2'h0));
    wr(spl_pkg::OFS_CMD, mk(4'h6, 8'h00, 1'b0, 2'h0));
    wr(spl_pkg::OFS_CMD, mk(4'h9, 8'h00, 1'b0, 2'h0));
    rd("bad unlock", spl_pkg::OFS_STAT, 32'h0000000b);
    // Host waits out the unlock gap before retrying
    repeat (UNLK + 5) @(posedge pclk);
    wr(spl_pkg::OFS_CMD, mk(4'h9, 8'h00, 1'b0, 2'h0));
    rd("gap over", spl_pkg::OFS_STAT, 32'h00000008);
    pwd(32'h12345678, 32'h89abcdef);
    wr(spl_pkg::OFS_CMD, mk(4'h6, 8'h00, 1'b0, 2'h0));
    rd("good unlock", spl_pkg::OFS_STAT, 32'h0000000c);
    wr(spl_pkg::OFS_CMD, mk(4'h7, 8'h00, 1'b0, 2'h2));
    rd("mode kept", spl_pkg::OFS_STAT, 32'h0000000f);
    $display("test password done");
  endtask : hw_and_pwd
endmodule : tb_top
